// [core/cpu_register_file_sysregs.v]
// cpu register file: gprs, program counter and system register bank
`include "regfile_consts.vh"
// How it works
// RULE1: all general and system registers are 32 bits wide
// RULE2: thirty-two general registers, indices 0 to 31, data or address use
// RULE3: register 0 reads zero and ignores writes
// RULE4: register 30 drives the short load/store base output
// RULE5: pc stores only 26 bits; upper bits read zero
// RULE6: pc increment drops carry out of bit 25
// RULE7: pc bit 0 is always zero
// RULE8: system registers reached only by sysreg load/store by index
// RULE9: fixed index map for saved pc/status, cause, status, table base
// RULE10: cause register readable by store, load cannot write it
// RULE11: reserved indices ignored on write, read as zero
// RULE12: debug pair writable only between debug trap and debug return
// RULE13: bit 0 of restored saved pc ignored on return
// RULE14: interrupt or exception saves pc and status to interrupt pair
// RULE15: nmi saves pc and status to nmi pair instead
// RULE16: saved pc is address of the next instruction
// RULE17: saved pc bits 31-26 and saved status bits 31-8 read zero
// RULE18: interrupt return restores pc and status from interrupt pair
// RULE19: status load takes effect after it, interrupt ack held meanwhile
// RULE20: two gpr read ports, one write port, register 0 bypassed
module cpu_register_file_sysregs #(
   parameter DW = `DATA_W,
   parameter AW = `IDX_W
) (
   input wire i_clock,
   input wire i_rst_n,
   input wire [AW-1:0] i_gpr_ra,
   input wire [AW-1:0] i_gpr_rb,
   input wire i_gpr_we,
   input wire [AW-1:0] i_gpr_wa,
   input wire [DW-1:0] i_gpr_wd,
   output reg [DW-1:0] o_gpr_qa,
   output reg [DW-1:0] o_gpr_qb,
   output reg [DW-1:0] o_short_base,
   input wire i_pc_step,
   input wire i_pc_load,
   input wire [DW-1:0] i_pc_target,
   output reg [DW-1:0] o_pc,
   input wire i_sysreg_load_insn,
   input wire i_sysreg_store_insn,
   input wire [AW-1:0] i_sr_idx,
   input wire [DW-1:0] i_sr_wd,
   output reg [DW-1:0] o_sr_rd,
   input wire i_int_accept,
   input wire i_nmi_accept,
   input wire [DW-1:0] i_next_pc,
   input wire [DW-1:0] i_cause_code,
   input wire [DW-1:0] i_status_in,
   input wire i_status_we,
   input wire i_interrupt_return_insn,
   input wire i_nmi_return,
   input wire i_table_call_return,
   input wire i_debug_return_insn,
   input wire i_debug_trap_insn,
   output reg [DW-1:0] o_status,
   output reg o_ack_hold
);
   reg rst_s1_ff;
   reg rst_s2_ff;
   wire rst_n;
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   assign rst_n = rst_s2_ff;

   function [DW-1:0] pc_ext;
      input [`PC_W-1:0] p;
      begin
         pc_ext = {{(DW-`PC_W){1'b0}}, p};
      end
   endfunction
   function [`PC_W-1:0] pc_even;
      input [DW-1:0] v;
      begin
         pc_even = {v[`PC_W-1:1], 1'b0};
      end
   endfunction
   function [DW-1:0] st_ext;
      input [`STAT_W-1:0] s;
      begin
         st_ext = {{(DW-`STAT_W){1'b0}}, s};
      end
   endfunction

   // registered read data, write port through the storage module
   wire [DW-1:0] qa;
   wire [DW-1:0] qb;
   reg zero_a_ff;
   reg zero_b_ff;
   reg [DW-1:0] base_ff;
   gpr_mem #(.DW(DW), .AW(AW)) u_gpr (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_ra(i_gpr_ra),
      .i_rb(i_gpr_rb),
      .i_we(i_gpr_we),
      .i_wa(i_gpr_wa),
      .i_wd(i_gpr_wd),
      .o_qa(qa),
      .o_qb(qb)
   ); // [RULE1] [RULE2] [RULE20]

   always @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         zero_a_ff <= 1'b1;
         zero_b_ff <= 1'b1;
         base_ff <= `ZERO32;
      end else begin
         zero_a_ff <= (i_gpr_ra == `GPR_ZERO); // [RULE20]
         zero_b_ff <= (i_gpr_rb == `GPR_ZERO); // [RULE20]
         if (i_gpr_we && i_gpr_wa == `GPR_BASE) begin
            base_ff <= i_gpr_wd; // [RULE4]
         end
      end
   end
   // muxing after the memory flops keeps zero reads independent of storage
   always @* begin
      o_gpr_qa = zero_a_ff ? `ZERO32 : qa; // [RULE3]
      o_gpr_qb = zero_b_ff ? `ZERO32 : qb; // [RULE3]
      o_short_base = base_ff; // [RULE4]
   end

   reg [`PC_W-1:0] pc_ff;
   reg [`PC_W-1:0] nxt_pc;
   reg [`PC_W-1:0] int_pc_ff;
   reg [`PC_W-1:0] nmi_pc_ff;
   reg [`PC_W-1:0] tc_pc_ff;
   reg [`PC_W-1:0] dbg_pc_ff;
   reg [`STAT_W-1:0] int_st_ff;
   reg [`STAT_W-1:0] nmi_st_ff;
   reg [`STAT_W-1:0] tc_st_ff;
   reg [`STAT_W-1:0] dbg_st_ff;
   reg [`STAT_W-1:0] status_ff;
   reg [DW-1:0] cause_ff;
   reg [DW-1:0] tc_base_ff;
   reg dbg_win_ff;
   reg hold_ff;
   reg [DW-1:0] rd_ff;
   reg [DW-1:0] nxt_rd;

   wire ld = i_sysreg_load_insn;
   wire wr_dbg = ld && dbg_win_ff; // [RULE12]
   wire any_save = i_int_accept || i_nmi_accept;

   always @* begin
      nxt_pc = pc_ff;
      if (i_interrupt_return_insn) begin
         nxt_pc = {int_pc_ff[`PC_W-1:1], 1'b0}; // [RULE13] [RULE18]
      end else if (i_nmi_return) begin
         nxt_pc = {nmi_pc_ff[`PC_W-1:1], 1'b0}; // [RULE13]
      end else if (i_table_call_return) begin
         nxt_pc = {tc_pc_ff[`PC_W-1:1], 1'b0}; // [RULE13]
      end else if (i_debug_return_insn) begin
         nxt_pc = {dbg_pc_ff[`PC_W-1:1], 1'b0};
      end else if (i_pc_load) begin
         nxt_pc = pc_even(i_pc_target); // [RULE7]
      end else if (i_pc_step) begin
         nxt_pc = pc_ff + `PC_STEP; // [RULE6]
      end
      nxt_pc[0] = 1'b0; // [RULE7] [RULE13]
   end

   always @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         pc_ff <= `PC_RESET;
         int_pc_ff <= `PC_RESET;
         nmi_pc_ff <= `PC_RESET;
         tc_pc_ff <= `PC_RESET;
         dbg_pc_ff <= `PC_RESET;
         int_st_ff <= `STATUS_RESET;
         nmi_st_ff <= `STATUS_RESET;
         tc_st_ff <= `STATUS_RESET;
         dbg_st_ff <= `STATUS_RESET;
         status_ff <= `STATUS_RESET;
         cause_ff <= `ZERO32;
         tc_base_ff <= `ZERO32;
         dbg_win_ff <= 1'b0;
         hold_ff <= 1'b0;
      end else begin
         pc_ff <= nxt_pc; // [RULE5]
         if (i_debug_trap_insn) begin
            dbg_win_ff <= 1'b1; // [RULE12]
         end else if (i_debug_return_insn) begin
            dbg_win_ff <= 1'b0; // [RULE12]
         end
         if (any_save) begin
            cause_ff <= i_cause_code;
         end
         hold_ff <= ld && i_sr_idx == `SR_STATUS; // [RULE19]
         if (i_interrupt_return_insn) begin
            status_ff <= int_st_ff; // [RULE18]
         end else if (i_nmi_return) begin
            status_ff <= nmi_st_ff;
         end else if (i_table_call_return) begin
            status_ff <= tc_st_ff;
         end else if (i_debug_return_insn) begin
            status_ff <= dbg_st_ff;
         end else if (ld && i_sr_idx == `SR_STATUS) begin
            status_ff <= i_sr_wd[`STAT_W-1:0]; // [RULE19]
         end else if (i_status_we) begin
            status_ff <= i_status_in[`STAT_W-1:0];
         end
         // hardware save wins over a software load in the same cycle
         if (i_nmi_accept) begin
            nmi_pc_ff <= pc_even(i_next_pc); // [RULE15] [RULE16]
            nmi_st_ff <= status_ff; // [RULE15]
         end else if (ld && i_sr_idx == `SR_NMI_PC) begin
            nmi_pc_ff <= i_sr_wd[`PC_W-1:0]; // [RULE8] [RULE9]
         end else if (ld && i_sr_idx == `SR_NMI_ST) begin
            nmi_st_ff <= i_sr_wd[`STAT_W-1:0]; // [RULE17]
         end
         if (i_int_accept && !i_nmi_accept) begin
            int_pc_ff <= pc_even(i_next_pc); // [RULE14] [RULE16]
            int_st_ff <= status_ff; // [RULE14]
         end else if (ld && i_sr_idx == `SR_INT_PC) begin
            int_pc_ff <= i_sr_wd[`PC_W-1:0]; // [RULE9] [RULE17]
         end else if (ld && i_sr_idx == `SR_INT_ST) begin
            int_st_ff <= i_sr_wd[`STAT_W-1:0]; // [RULE17]
         end
         if (ld && i_sr_idx == `SR_TC_PC) begin
            tc_pc_ff <= i_sr_wd[`PC_W-1:0]; // [RULE9]
         end
         if (ld && i_sr_idx == `SR_TC_ST) begin
            tc_st_ff <= i_sr_wd[`STAT_W-1:0];
         end
         if (wr_dbg && i_sr_idx == `SR_DBG_PC) begin
            dbg_pc_ff <= i_sr_wd[`PC_W-1:0]; // [RULE12]
         end
         if (wr_dbg && i_sr_idx == `SR_DBG_ST) begin
            dbg_st_ff <= i_sr_wd[`STAT_W-1:0]; // [RULE12]
         end
         if (ld && i_sr_idx == `SR_TC_BASE) begin
            tc_base_ff <= i_sr_wd; // [RULE1]
         end
      end
   end

   // cause has no load path at all; reserved indices read zero
   always @* begin
      nxt_rd = `ZERO32;
      case (i_sr_idx)
         `SR_INT_PC: nxt_rd = pc_ext(int_pc_ff); // [RULE17]
         `SR_INT_ST: nxt_rd = st_ext(int_st_ff); // [RULE17]
         `SR_NMI_PC: nxt_rd = pc_ext(nmi_pc_ff);
         `SR_NMI_ST: nxt_rd = st_ext(nmi_st_ff);
         `SR_CAUSE: nxt_rd = cause_ff; // [RULE10]
         `SR_STATUS: nxt_rd = st_ext(status_ff);
         `SR_TC_PC: nxt_rd = pc_ext(tc_pc_ff);
         `SR_TC_ST: nxt_rd = st_ext(tc_st_ff);
         `SR_DBG_PC: nxt_rd = pc_ext(dbg_pc_ff);
         `SR_DBG_ST: nxt_rd = st_ext(dbg_st_ff);
         `SR_TC_BASE: nxt_rd = tc_base_ff;
         default: nxt_rd = `ZERO32; // [RULE11]
      endcase
   end

   always @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_ff <= `ZERO32;
      end else if (i_sysreg_store_insn) begin
         rd_ff <= nxt_rd; // [RULE8] [RULE9]
      end
   end

   always @* begin
      o_pc = pc_ext(pc_ff); // [RULE5]
      o_sr_rd = rd_ff;
      o_status = st_ext(status_ff);
      o_ack_hold = hold_ff | (ld && i_sr_idx == `SR_STATUS); // [RULE19]
   end
endmodule

// [core/regfile_consts.vh]
// constants for the cpu register file and system register bank
`ifndef REGFILE_CONSTS_VH
`define REGFILE_CONSTS_VH
`define DATA_W 32
`define IDX_W 5
`define PC_W 26
`define STAT_W 8
`define GPR_ZERO 5'h00
`define GPR_BASE 5'h1e
`define SR_INT_PC 5'h00
`define SR_INT_ST 5'h01
`define SR_NMI_PC 5'h02
`define SR_NMI_ST 5'h03
`define SR_CAUSE 5'h04
`define SR_STATUS 5'h05
`define SR_TC_PC 5'h10
`define SR_TC_ST 5'h11
`define SR_DBG_PC 5'h12
`define SR_DBG_ST 5'h13
`define SR_TC_BASE 5'h14
`define STATUS_RESET 8'h20
`define PC_RESET 26'h000_0000
`define PC_STEP 26'h000_0002
`define ZERO32 32'h0000_0000
`endif

// [core/gpr_mem.v]
// general-purpose register storage, two registered read ports, one write
`include "regfile_consts.vh"
module gpr_mem #(
   parameter DW = `DATA_W,
   parameter AW = `IDX_W
) (
   input wire i_clock,
   input wire i_rst_n,
   input wire [AW-1:0] i_ra,
   input wire [AW-1:0] i_rb,
   input wire i_we,
   input wire [AW-1:0] i_wa,
   input wire [DW-1:0] i_wd,
   output reg [DW-1:0] o_qa,
   output reg [DW-1:0] o_qb
);
   reg [DW-1:0] mem_ff [0:(1<<AW)-1];
   integer k;
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (k = 0; k < (1<<AW); k = k + 1) begin
            mem_ff[k] <= `ZERO32;
         end
      end else if (i_we && i_wa != `GPR_ZERO) begin
         mem_ff[i_wa] <= i_wd;
      end
   end
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_qa <= `ZERO32;
         o_qb <= `ZERO32;
      end else begin
         o_qa <= mem_ff[i_ra];
         o_qb <= mem_ff[i_rb];
      end
   end
endmodule

// [test/regfile_chk.sv]
// port assertions for the cpu register file
module regfile_chk (
   input wire i_clock,
   input wire i_rst_n,
   input wire [4:0] i_gpr_ra,
   input wire [4:0] i_sr_idx,
   input wire [31:0] i_pc_target,
   input wire [31:0] i_sr_wd,
   input wire i_pc_step,
   input wire i_pc_load,
   input wire i_sysreg_load_insn,
   input wire i_sysreg_store_insn,
   input wire i_interrupt_return_insn,
   input wire i_nmi_return,
   input wire i_table_call_return,
   input wire i_debug_return_insn,
   input wire i_int_accept,
   input wire [31:0] o_gpr_qa,
   input wire [31:0] o_pc,
   input wire [31:0] o_sr_rd,
   input wire [31:0] o_status,
   input wire o_ack_hold
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   // returns outrank loads and steps, so those cases are left out
   wire ret = i_interrupt_return_insn | i_nmi_return |
      i_table_call_return | i_debug_return_insn;
   wire rsv = (i_sr_idx > 5'h05 && i_sr_idx < 5'h10) || i_sr_idx > 5'h14;
   wire st_ld = i_sysreg_load_insn && i_sr_idx == 5'h05;
   a_pc_range: assert property (
      o_pc[31:26] == 6'h00 && !o_pc[0]) else $error("pc out of range");
   a_pc_step_wrap: assert property (
      i_pc_step && !i_pc_load && !ret |=>
      o_pc == {6'h00, $past(o_pc[25:0]) + 26'h000_0002})
      else $error("pc step wrong");
   a_pc_load_even: assert property (
      i_pc_load && !ret |=>
      o_pc == {6'h00, $past(i_pc_target[25:1]), 1'b0})
      else $error("pc load wrong");
   a_zero_reg: assert property (
      i_gpr_ra == 5'h00 |=> o_gpr_qa == 32'h0000_0000)
      else $error("register zero not zero");
   a_status_load: assert property (
      st_ld && !ret |=> o_status == {24'h00_0000, $past(i_sr_wd[7:0])})
      else $error("status load wrong");
   a_ack_hold: assert property (
      st_ld |-> o_ack_hold ##1 o_ack_hold) else $error("ack not held");
   a_rsv_read: assert property (
      i_sysreg_store_insn && rsv |=> o_sr_rd == 32'h0000_0000)
      else $error("reserved read not zero");
   a_store_holds: assert property (
      !i_sysreg_store_insn |=> $stable(o_sr_rd))
      else $error("read data moved");
   a_status_upper: assert property (
      o_status[31:8] == 24'h00_0000) else $error("status upper set");
   cover property (i_pc_step && o_pc[25:0] == 26'h3ff_fffe);
   cover property (i_int_accept);
   cover property (i_sysreg_load_insn && i_sr_idx == 5'h12);
endmodule
bind cpu_register_file_sysregs regfile_chk u_chk (.*);

// [test/pipe_model.sv]
// pipeline stand-in issuing pc step pulses
module pipe_model (
   input wire logic i_clock,
   input wire logic i_run,
   output logic o_step
);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_step = 1'b0;
   // one step per cycle of run, a cycle late as a real issue stage
   always @(posedge i_clock) begin
      o_step <= i_run;
   end
endmodule

// [test/tb_top.sv]
// self-checking bench for the cpu register file
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [4:0] x; logic [31:0] d; logic [31:0] e;} row_t;
   logic i_clock = 0, i_rst_n = 0, run = 0, i_status_we, i_nmi_return;
   logic i_table_call_return, o_ack_hold;
   logic [8:0] sb;
   logic [4:0] i_gpr_ra, i_gpr_rb, i_gpr_wa, i_sr_idx;
   logic [31:0] i_gpr_wd, i_pc_target, i_sr_wd, i_next_pc, i_cause_code;
   logic [31:0] i_status_in, o_gpr_qa, o_gpr_qb, o_short_base, o_pc;
   logic [31:0] o_sr_rd, o_status;
   wire i_pc_step;
   wire i_sysreg_load_insn = sb[0];
   wire i_sysreg_store_insn = sb[1];
   wire i_int_accept = sb[2];
   wire i_nmi_accept = sb[3];
   wire i_interrupt_return_insn = sb[4];
   wire i_debug_trap_insn = sb[5];
   wire i_debug_return_insn = sb[6];
   wire i_pc_load = sb[7];
   wire i_gpr_we = sb[8];
   int fails = 0, checks_done = 0;
   row_t rows[13] = '{'{5'h00, 32'hffff_fffe, 32'h03ff_fffe},
      '{5'h01, 32'hffff_ffa5, 32'h0000_00a5},
      '{5'h02, 32'h0412_3456, 32'h0012_3456},
      '{5'h03, 32'h0000_0107, 32'h0000_0007},
      '{5'h04, 32'h0000_0055, 32'h0000_0000},
      '{5'h05, 32'h0000_00c3, 32'h0000_00c3},
      '{5'h07, 32'hffff_ffff, 32'h0000_0000},
      '{5'h10, 32'h0000_1234, 32'h0000_1234},
      '{5'h11, 32'h1234_565a, 32'h0000_005a},
      '{5'h12, 32'h0000_0400, 32'h0000_0000},
      '{5'h13, 32'h0000_0011, 32'h0000_0020},
      '{5'h14, 32'hdead_beef, 32'hdead_beef},
      '{5'h15, 32'hffff_ffff, 32'h0000_0000}};
   cpu_register_file_sysregs DUT (.*);
   pipe_model u_pipe (.i_clock(i_clock), .i_run(run), .o_step(i_pc_step));
   always #20 i_clock = ~i_clock;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one strobe for one cycle; all data buses but i_status_in carry the same value
   task go(input int k, input logic [4:0] x, input logic [31:0] d);
      @(posedge i_clock);
      sb[k] <= 1'b1;
      i_sr_idx <= x;
      i_gpr_wa <= x;
      {i_sr_wd, i_gpr_wd, i_pc_target, i_next_pc, i_cause_code} <= {5{d}};
      @(posedge i_clock);
      sb <= '0;
      #1;
   endtask
   initial begin
      repeat (5000) @(posedge i_clock);
      fails++;
      print_verdict;
   end
   initial begin
      sb = '0;
      {i_status_we, i_nmi_return, i_table_call_return} = '0;
      {i_gpr_ra, i_gpr_rb, i_gpr_wa, i_sr_idx} = '0;
      {i_gpr_wd, i_pc_target, i_sr_wd, i_next_pc} = '0;
      {i_cause_code, i_status_in} = '0;
      repeat (6) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      #1;
      chk(o_pc, 32'h0000_0000);
      chk(o_status, 32'h0000_0020);
      foreach (rows[i]) begin
         go(0, rows[i].x, rows[i].d);
         go(1, rows[i].x, 32'h0000_0000);
         chk(o_sr_rd, rows[i].e);
      end
      go(8, 5'h00, 32'hffff_ffff);
      go(8, 5'h1f, 32'ha5a5_a5a5);
      go(8, 5'h1e, 32'h0000_3000);
      i_gpr_rb <= 5'h1f;
      repeat (2) @(posedge i_clock);
      #1;
      chk(o_gpr_qa, 32'h0000_0000);
      chk(o_gpr_qb, 32'ha5a5_a5a5);
      chk(o_short_base, 32'h0000_3000);
      go(7, 5'h00, 32'hffff_fffd);
      chk(o_pc, 32'h03ff_fffc);
      @(posedge i_clock);
      run <= 1'b1;
      repeat (2) @(posedge i_clock);
      run <= 1'b0;
      repeat (3) @(posedge i_clock);
      #1;
      chk(o_pc, 32'h0000_0000);
      go(2, 5'h00, 32'h0000_1000);
      go(1, 5'h00, 32'h0000_0000);
      chk(o_sr_rd, 32'h0000_1000);
      go(1, 5'h01, 32'h0000_0000);
      chk(o_sr_rd, 32'h0000_00c3);
      go(1, 5'h04, 32'h0000_0000);
      chk(o_sr_rd, 32'h0000_1000);
      go(0, 5'h00, 32'h0000_2001);
      go(0, 5'h05, 32'h0000_0011);
      chk({31'h0, o_ack_hold}, 32'h0000_0001);
      chk(o_status, 32'h0000_0011);
      go(4, 5'h00, 32'h0000_0000);
      chk(o_pc, 32'h0000_2000);
      chk(o_status, 32'h0000_00c3);
      go(3, 5'h00, 32'h0000_3000);
      go(1, 5'h02, 32'h0000_0000);
      chk(o_sr_rd, 32'h0000_3000);
      go(1, 5'h00, 32'h0000_0000);
      chk(o_sr_rd, 32'h0000_2001);
      go(5, 5'h00, 32'h0000_0000);
      go(0, 5'h12, 32'h0000_0500);
      go(1, 5'h12, 32'h0000_0000);
      chk(o_sr_rd, 32'h0000_0500);
      go(6, 5'h00, 32'h0000_0000);
      go(0, 5'h12, 32'h0000_0600);
      go(1, 5'h12, 32'h0000_0000);
      chk(o_sr_rd, 32'h0000_0500);
      // nmi and table call returns restore from their own pairs
      @(posedge i_clock);
      i_nmi_return <= 1'b1;
      @(posedge i_clock);
      i_nmi_return <= 1'b0;
      #1;
      chk(o_pc, 32'h0000_3000);
      chk(o_status, 32'h0000_00c3);
      @(posedge i_clock);
      i_table_call_return <= 1'b1;
      @(posedge i_clock);
      i_table_call_return <= 1'b0;
      #1;
      chk(o_pc, 32'h0000_1234);
      chk(o_status, 32'h0000_005a);
      @(posedge i_clock);
      i_status_in <= 32'hffff_ff44;
      i_status_we <= 1'b1;
      @(posedge i_clock);
      i_status_we <= 1'b0;
      #1;
      chk(o_status, 32'h0000_0044);
      print_verdict;
   end
endmodule
